/* rtl/asfs_defines.svh */
`ifndef ASFS_DEFINES_SVH
`define ASFS_DEFINES_SVH
// serial clock edges in one conversion
`define ASFS_CONV_EDGES 5'h10
// last falling edge of the track phase
`define ASFS_TRACK_LAST 5'h03
// falling edge that holds the input
`define ASFS_HOLD_EDGE 5'h04
// falling edges that carry the result
`define ASFS_DATA_FIRST 5'h05
`define ASFS_DATA_LAST 5'h0C
// rising edge that completes the control word
`define ASFS_CTRL_LAST 5'h08
// position of the channel field in the control word
`define ASFS_CHAN_LSB 3
// channel selected after reset
`define ASFS_CHAN_RST 3'h0
// result words buffered toward the serializer
`define ASFS_FIFO_DEPTH 32
`endif

/* rtl/asfs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module asfs_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 32
) (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];   // storage
  logic [AW-1:0] wr_ff;        // write pointer
  logic [AW-1:0] rd_ff;        // read pointer
  logic [AW:0] cnt_ff;         // words held
  logic ready_ff;              // room left, a flop so ready never glitches
  logic empty_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_cnt;

  assign push = in_valid && ready_ff;
  assign pop = out_ready && !empty_ff;
  assign in_ready = ready_ff;
  assign out_valid = !empty_ff;
  assign out_data = mem[rd_ff];

  // occupancy, pushes and pops may coincide
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // pointers and flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      ready_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      ready_ff <= (nxt_cnt != (AW+1)'(DEPTH));
      empty_ff <= (nxt_cnt == '0);
    end
  end

  // storage has no reset, nothing reads an empty slot
  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem[wr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* rtl/asfs_pkg.sv */
`default_nettype none
package asfs_pkg;
  // one converted word with the channel it came from
  typedef struct packed {
    logic [2:0] chan;
    logic [7:0] code;
  } asfs_sample_t;
  // phase of the converter inside a frame
  typedef enum logic [1:0] {
    ASFS_IDLE = 2'b00,
    ASFS_TRACK = 2'b01,
    ASFS_CONVERT = 2'b10
  } asfs_state_t;
endpackage
`default_nettype wire

/* rtl/asfs_sequencer.sv */
// How it works
// - chip select low frames every transfer
// - output driven only while chip select low
// - serial clock ignored while chip select high
// - first three falling edges are tracking
// - next thirteen cycles convert and shift out
// - zeros, eight result bits MSB first, zeros
// - retrack on fall after each sixteenth rise
// - hold again at fourth fall of conversion
// - select falls, clock high: next fall counts
// - select falls, clock low: counts as edge
// - input held at fourth falling edge
// - control word shifted on first eight rises
// - word bits five to three pick channel
// - channel zero selected after reset
// - simultaneous falls also start tracking
`timescale 1ns/1ps
`default_nettype none
`include "asfs_defines.svh"
module asfs_sequencer #(
  parameter int DEPTH = `ASFS_FIFO_DEPTH
) (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  output logic dout,
  output logic dout_oe_n,
  // analog front end
  output logic track,
  output logic hold_req,
  output logic [2:0] hold_chan,
  input wire logic sample_valid,
  input wire asfs_pkg::asfs_sample_t sample_word,
  output logic sample_ready
);
  // pin synchronisers, bit 0 select, bit 1 clock, bit 2 data
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;   // delayed copy for edge detection
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic cs_fall;
  logic cs_rise;
  logic fall_evt;      // one counted falling edge
  logic rise_evt;      // one counted rising edge
  logic new_conv;
  asfs_pkg::asfs_state_t state_ff;
  asfs_pkg::asfs_state_t nxt_state;
  logic [4:0] fcnt_ff;  // falling edges in this conversion
  logic [4:0] rcnt_ff;  // rising edges in this conversion
  logic [4:0] nxt_fcnt;
  logic [6:0] ctrl_ff;  // control word shifted in so far
  logic [7:0] ctrl_word;
  logic [2:0] chan_ff;  // channel for the next hold
  logic [7:0] sh_ff;    // result bits still to leave
  logic dout_ff;
  logic oe_n_ff;
  logic track_ff;
  logic hold_ff;
  logic [2:0] hchan_ff;
  logic pop;
  logic fifo_valid;
  logic fifo_in_ready;
  asfs_pkg::asfs_sample_t fifo_word;

  // two flops before any logic sees a pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
      s3_ff <= 3'h1;
    end else if (ce) begin
      s1_ff <= {din_pin, sclk_pin, cs_n_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign cs_n_s = s2_ff[0];
  assign sclk_s = s2_ff[1];
  assign din_s = s2_ff[2];
  assign cs_fall = s3_ff[0] && !cs_n_s;
  assign cs_rise = !s3_ff[0] && cs_n_s;
  // clock edges only count while selected
  assign fall_evt = !cs_n_s && ((s3_ff[1] && !sclk_s) || (cs_fall && !sclk_s));
  assign rise_evt = !cs_n_s && !s3_ff[1] && sclk_s && (state_ff != asfs_pkg::ASFS_IDLE);
  // a fall after the sixteenth rise opens the next conversion
  assign new_conv = fall_evt && ((state_ff == asfs_pkg::ASFS_IDLE)
                    || (rcnt_ff == `ASFS_CONV_EDGES));
  assign nxt_fcnt = new_conv ? 5'h01 : ((fcnt_ff == 5'h1F) ? fcnt_ff : fcnt_ff + 5'h01);
  assign ctrl_word = {ctrl_ff, din_s};
  assign pop = fall_evt && (nxt_fcnt == `ASFS_DATA_FIRST);

  // phase decision
  always_comb begin
    nxt_state = state_ff;
    if (cs_n_s) begin
      nxt_state = asfs_pkg::ASFS_IDLE;
    end else if (fall_evt) begin
      if (nxt_fcnt <= `ASFS_TRACK_LAST) begin
        nxt_state = asfs_pkg::ASFS_TRACK;
      end else begin
        nxt_state = asfs_pkg::ASFS_CONVERT;
      end
    end
  end

  // phase and edge counters, dropped whenever select is high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= asfs_pkg::ASFS_IDLE;
      fcnt_ff <= 5'h00;
      rcnt_ff <= 5'h00;
      track_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      track_ff <= (nxt_state == asfs_pkg::ASFS_TRACK);
      if (cs_n_s) begin
        fcnt_ff <= 5'h00;
        rcnt_ff <= 5'h00;
      end else begin
        if (fall_evt) begin
          fcnt_ff <= nxt_fcnt;
        end
        if (new_conv) begin
          rcnt_ff <= 5'h00;
        end else if (rise_evt && rcnt_ff != 5'h1F) begin
          rcnt_ff <= rcnt_ff + 5'h01;
        end
      end
    end
  end

  // hold strobe to the front end, with the latched channel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 1'b0;
      hchan_ff <= `ASFS_CHAN_RST;
    end else if (ce) begin
      hold_ff <= fall_evt && !new_conv && (nxt_fcnt == `ASFS_HOLD_EDGE);
      if (fall_evt && !new_conv && (nxt_fcnt == `ASFS_HOLD_EDGE)) begin
        hchan_ff <= chan_ff;
      end
    end
  end

  // control word capture, the host refreshes it each conversion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 7'h00;
      chan_ff <= `ASFS_CHAN_RST;
    end else if (ce) begin
      if (rise_evt && rcnt_ff < `ASFS_CTRL_LAST) begin
        ctrl_ff <= ctrl_word[6:0];
        if (rcnt_ff == `ASFS_CTRL_LAST - 5'h01) begin
          chan_ff <= ctrl_word[`ASFS_CHAN_LSB +: 3];
        end
      end
    end
  end

  // output shifter; an empty buffer sends zeros rather than stalling the link
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dout_ff <= 1'b0;
      sh_ff <= 8'h00;
      oe_n_ff <= 1'b1;
    end else if (ce) begin
      oe_n_ff <= cs_n_s;
      if (cs_n_s) begin
        dout_ff <= 1'b0;
      end else if (fall_evt) begin
        if (pop) begin
          dout_ff <= fifo_valid && fifo_word.code[7];
          sh_ff <= fifo_valid ? {fifo_word.code[6:0], 1'b0} : 8'h00;
        end else if (!new_conv && nxt_fcnt > `ASFS_DATA_FIRST
                     && nxt_fcnt <= `ASFS_DATA_LAST) begin
          dout_ff <= sh_ff[7];
          sh_ff <= {sh_ff[6:0], 1'b0};
        end else begin
          dout_ff <= 1'b0;
        end
      end
    end
  end

  // results wait here between front end and shifter
  asfs_fifo #(
    .W($bits(asfs_pkg::asfs_sample_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(sample_valid),
    .in_ready(fifo_in_ready),
    .in_data(sample_word),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_word)
  );

  assign dout = dout_ff;
  assign dout_oe_n = oe_n_ff;
  assign track = track_ff;
  assign hold_req = hold_ff;
  assign hold_chan = hchan_ff;
  assign sample_ready = fifo_in_ready;

  // checks next to the logic
  AST_OE_DESELECT: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cs_n_s) |=> dout_oe_n && !dout) else $error("output driven while deselected");
  AST_OE_SELECT: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && !cs_n_s) |=> !dout_oe_n) else $error("output not driven while selected");
  AST_GATED: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cs_n_s) |=> !track && !hold_req && fcnt_ff == 5'h00) else $error("clock seen deselected");
  AST_TRACK_SPAN: assert property (@(posedge clock) disable iff (!rst_n)
    track |-> (fcnt_ff >= 5'h01 && fcnt_ff <= 5'h03)) else $error("track outside edges one to three");
  AST_CONV_SPAN: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff == asfs_pkg::ASFS_CONVERT) |-> fcnt_ff >= 5'h04) else $error("convert too early");
  AST_HOLD_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
    hold_req |-> (fcnt_ff == 5'h04 && $past(track))) else $error("hold not at fourth fall");
  AST_LEAD_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall_evt && (new_conv || nxt_fcnt < 5'h05)) |=> !dout) else $error("leading bit not zero");
  AST_TRAIL_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall_evt && !new_conv && nxt_fcnt > 5'h0C) |=> !dout) else $error("trailing bit not zero");
  AST_RETRACK: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && fall_evt && rcnt_ff == 5'h10) |=> track && fcnt_ff == 5'h01) else $error("no retrack");
  AST_CS_LOW_CLK: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cs_fall && !sclk_s) |=> track && fcnt_ff == 5'h01) else $error("select fall not edge one");
  AST_CS_HIGH_CLK: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cs_fall && sclk_s) |=> state_ff == asfs_pkg::ASFS_IDLE) else $error("counted early");
  AST_CHAN_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rise_evt && rcnt_ff == 5'h07) |=> chan_ff == $past(ctrl_word[5:3])) else $error("bad channel");
endmodule
`default_nettype wire

/* testbench/adc_serial_frame_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_frame_sequencer_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sample_valid = 1'b0;
  asfs_pkg::asfs_sample_t sample_word = '0;
  logic cs_n, sclk, din, dout, dout_oe_n, track, hold_req, sample_ready, took;
  logic [2:0] hold_chan;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  int holds = 0;  // hold strobes seen since start
  always #5 clock = ~clock;
  // count one-cycle hold strobes from the front-end side
  always @(posedge clock) begin
    if (hold_req === 1'b1) holds <= holds + 1;
  end
  // small fifo so that filling it is quick
  asfs_sequencer #(.DEPTH(4)) DUT (.clock(clock), .rst_n(rst_n), .ce(1'b1),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .din_pin(din), .dout(dout),
    .dout_oe_n(dout_oe_n), .track(track), .hold_req(hold_req), .hold_chan(hold_chan),
    .sample_valid(sample_valid), .sample_word(sample_word), .sample_ready(sample_ready));
  asfs_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe_n(dout_oe_n), .track(track), .hold_chan(hold_chan));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // front end offers one word, held until taken or the wait runs out
  task automatic push(input logic [7:0] v, output logic ok);
    int t;
    ok = 1'b0;
    @(posedge clock) sample_valid <= 1'b1;
    sample_word <= '{chan: 3'h0, code: v};
    for (t = 0; t < 20 && !ok; t++) begin
      @(posedge clock);
      if (sample_ready === 1'b1) ok = 1'b1;
    end
    sample_valid <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset();
    repeat (3) @(posedge clock);
    chk(dout_oe_n === 1'b1 && dout === 1'b0, "reset pins");
    chk(hold_chan === 3'h0 && track === 1'b0, "reset chan");
    chk(hold_req === 1'b0 && sample_ready === 1'b1, "reset strobes");
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  // fill until refused, then eight back-to-back conversions drain it
  task automatic t_fill_and_run();
    int h0;
    for (n = 0; n < 4; n++) begin
      push(8'hA0 + 8'(n), took);
      chk(took === 1'b1, "push refused");
    end
    push(8'hFF, took);
    chk(took === 1'b0 && sample_ready === 1'b0, "full fifo took a word");
    h0 = holds;
    host.frame(128, 1'b1, 3'h0, 1'b0);
    chk(holds - h0 == 8, "one hold per conversion");
    for (n = 0; n < 8; n++) begin
      chk(host.rx[n] === {4'h0, (n < 4) ? 8'hA0 + 8'(n) : 8'h00, 4'h0}, "data");
      chk(host.trk[n] === 16'hE000, "track window");
      chk(host.hc[n] === ((n == 0) ? 3'h0 : 3'(n - 1)), "channel");
    end
    chk(host.oe_bad === 1'b0, "output not enabled in frame");
    repeat (10) @(posedge clock);
    chk(dout_oe_n === 1'b1 && dout === 1'b0, "output after frame");
  endtask
  // early select rise, then a clean frame started on a low clock
  task automatic t_abort();
    push(8'h5C, took);
    host.frame(12, 1'b0, 3'h7, 1'b0);
    chk(host.rx[0][15:4] === {4'h0, 8'h5C}, "low-clock start");
    repeat (10) @(posedge clock);
    chk(dout_oe_n === 1'b1 && dout === 1'b0, "output after abort");
    push(8'h3A, took);
    host.frame(16, 1'b0, 3'h2, 1'b0);
    chk(host.rx[0] === {4'h0, 8'h3A, 4'h0}, "frame after abort");
    chk(host.trk[0] === 16'hE000, "track after abort");
  endtask
  // select and clock fall together; the channel sent last frame is held
  task automatic t_together();
    push(8'hC3, took);
    host.frame(16, 1'b1, 3'h4, 1'b1);
    chk(host.rx[0] === {4'h0, 8'hC3, 4'h0}, "simultaneous start");
    chk(host.trk[0] === 16'hE000, "simultaneous track");
    chk(host.hc[0] === 3'h2, "channel across frames");
  endtask
  initial begin
    t_reset();
    repeat (4) @(posedge clock);
    t_fill_and_run();
    t_abort();
    t_together();
    tally_and_finish();
  end
  // watchdog well beyond the roughly 3000 cycles of traffic
  initial begin
    repeat (50000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* testbench/asfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asfs_host_model (
  // clocking
  input wire logic clock,
  // serial pins toward the device
  output logic cs_n,
  output logic sclk,
  output logic din,
  // device answers
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic track,
  input wire logic [2:0] hold_chan
);
  // serial clock half period is H+1 system cycles; slow enough for the sync
  localparam int H = 6;
  logic [15:0] rx [8];
  logic [15:0] trk [8];
  logic [2:0] hc [8];
  logic oe_bad;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    oe_bad = 1'b0;
  end
  // one frame of nedge rises; channel code c+n is sent in conversion n
  // together: select and clock fall on the same edge
  task automatic frame(input int nedge, input logic start_high, input logic [2:0] c,
                       input logic together);
    int k;
    int b;
    logic [7:0] ctl;
    if (!start_high) begin
      // toggles while deselected must not count
      for (k = 0; k < 3; k++) begin
        @(posedge clock) sclk <= 1'b0;
        repeat (H) @(posedge clock);
        @(posedge clock) sclk <= 1'b1;
        repeat (H) @(posedge clock);
      end
      @(posedge clock) sclk <= 1'b0;
      repeat (H) @(posedge clock);
    end
    @(posedge clock) cs_n <= 1'b0;
    if (together) sclk <= 1'b0;
    repeat (H) @(posedge clock);
    for (k = 0; k < nedge; k++) begin
      b = k % 16;
      ctl = {2'b11, 3'(c + 3'(k / 16)), 3'b111};
      @(posedge clock);
      // with select falling on a low clock, that fall is edge one
      if (k > 0 || (start_high && !together)) sclk <= 1'b0;
      // unused bit times carry a changing level, never a held one
      din <= (b < 8) ? ctl[7-b] : ~din;
      repeat (H) @(posedge clock);
      rx[k/16][15-b] = dout;
      trk[k/16][15-b] = track;
      if (dout_oe_n !== 1'b0) oe_bad = 1'b1;
      if (b == 15) hc[k/16] = hold_chan;
      @(posedge clock) sclk <= 1'b1;
      repeat (H) @(posedge clock);
    end
    @(posedge clock) cs_n <= 1'b1;
    din <= ~din;
    repeat (H) @(posedge clock);
  endtask
endmodule
`default_nettype wire
